//--- src/rtcs_map.svh
`ifndef RTCS_MAP_SVH
`define RTCS_MAP_SVH
// ==========================================
// register pointer space
`define RTCS_PTR_FIRST 6'h00
`define RTCS_PTR_LAST 6'h3f
// ==========================================
// slave address; value is arbitrary
`define RTCS_DEV_ADDR 7'h2a
// ==========================================
// reset levels of the filtered bus lines (pulled up)
`define RTCS_LINE_RESET 1'b1
// index of the acknowledge bit within a byte slot
`define RTCS_ACK_BIT 4'h8
// ==========================================
// timing: host clock and standard-mode bus rate
`define RTCS_CLK_KHZ 25000
`define RTCS_SCL_KHZ 100
// quarter of an scl period, rounded up so scl never runs above the rate
`define RTCS_QUARTER ((`RTCS_CLK_KHZ + 4 * `RTCS_SCL_KHZ - 1) / (4 * `RTCS_SCL_KHZ))
`endif

//--- src/rtcs_pkg.sv
package rtcs_pkg;
	// ==========================================
	// shared types
	typedef logic [5:0] rtcs_ptr_t; // register pointer
	// device states, gray along address -> receive/transmit path
	typedef enum logic [2:0] {
		DEV_IDLE = 3'h0,
		DEV_HDR = 3'h1, // receiving the address byte
		DEV_ADDR_ACK = 3'h3,
		DEV_RX = 3'h2,
		DEV_RX_ACK = 3'h6,
		DEV_TX = 3'h7,
		DEV_TX_ACK = 3'h5
	} rtcs_dev_state_t;
	// host states
	typedef enum logic [2:0] {
		HST_IDLE = 3'h0,
		HST_START = 3'h1,
		HST_BIT = 3'h3,
		HST_HOLD = 3'h2,
		HST_STOP = 3'h6
	} rtcs_host_state_t;
	// host commands
	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_WRITE = 2'h1,
		OP_READ = 2'h2,
		OP_STOP = 2'h3
	} rtcs_op_t;
	// ==========================================
	// glitch filter state
	typedef struct packed {
		logic s1; // first synchroniser stage
		logic s2; // second synchroniser stage
		logic s3; // one more sample for agreement
		logic level; // filtered level
	} rtcs_filt_st_t;
	// device state
	typedef struct packed {
		rtcs_dev_state_t state;
		logic scl_q; // previous filtered scl
		logic sda_q; // previous filtered sda
		logic [3:0] bitcnt;
		logic [7:0] sh; // shift register
		logic rw; // direction bit of the address
		logic ptr_phase; // next written byte loads the pointer
		logic acked; // master acknowledged the last sent byte
		rtcs_ptr_t ptr;
		logic [7:0] wr_data;
		logic wr_strobe;
		logic snap;
		logic drive_low; // pulls sda low
		logic busy;
	} rtcs_dev_st_t;
	// host state
	typedef struct packed {
		rtcs_host_state_t state;
		logic [7:0] cnt; // quarter-period counter
		logic [1:0] phase; // quarter within a bit or condition
		logic [3:0] bitcnt;
		logic [7:0] sh;
		logic rd; // byte slot is a read
		logic nack; // read ends with not-acknowledge
		logic scl_low;
		logic sda_low;
		logic ready;
		logic rsp_valid;
		logic [7:0] rsp_data;
		logic rsp_ack;
	} rtcs_host_st_t;
endpackage

//--- src/rtcs_if.sv
// ==========================================
// two-wire bus between host and device, both lines pulled up
interface rtcs_if;
	logic scl_m_o; // host scl output level
	logic scl_m_oe; // host drives scl
	logic sda_m_o; // host sda output level
	logic sda_m_oe; // host drives sda
	logic sda_s_o; // device sda output level
	logic sda_s_oe; // device drives sda
	logic scl; // resolved scl
	logic sda; // resolved sda
	// wired-and with pull-up
	assign scl = ~(scl_m_oe & ~scl_m_o);
	assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
	modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
	modport mst (input scl, input sda, output scl_m_o, output scl_m_oe,
		output sda_m_o, output sda_m_oe);
endinterface

//--- src/rtcs_filter.sv
`include "rtcs_map.svh"
// ==========================================
// two-flop synchroniser plus agreement filter for one bus line
module rtcs_filter (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic raw_in,
	output logic level_out
);
	import rtcs_pkg::*;
	rtcs_filt_st_t r_reg; // all state
	rtcs_filt_st_t r_next;
	// ==========================================
	// next state
	always_comb
	begin
		r_next = r_reg;
		r_next.s1 = raw_in;
		r_next.s2 = r_reg.s1; // only reader of the first stage
		r_next.s3 = r_reg.s2;
		// a level must be seen twice, so a one-sample glitch never passes
		if (r_reg.s2 == r_reg.s3)
		begin
			r_next.level = r_reg.s3;
		end
	end
	// ==========================================
	// registers
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			r_reg <= '{s1: `RTCS_LINE_RESET, s2: `RTCS_LINE_RESET,
				s3: `RTCS_LINE_RESET, level: `RTCS_LINE_RESET};
		end
		else
		begin
			r_reg <= r_next;
		end
	end
	assign level_out = r_reg.level;
endmodule

//--- src/rtcs_slave.sv
// Behaviour
// - bus idle only when both lines high
// - sda fall with scl high is start
// - sda rise with scl high is stop
// - sda changes only while scl low
// - master starts only on idle bus
// - eight-bit bytes plus receiver acknowledge bit
// - standard 100 kHz rate only
// - master clocks an extra acknowledge pulse
// - acknowledger holds sda low through high
// - master nack ends read; device releases sda
// - every byte shifted msb first
// - unlimited bytes between start and stop
// - repeated start begins fresh address phase
// - address match acknowledged, else stay passive
// - direction 0 writes; first byte loads pointer
// - write bytes acknowledged and stored at pointer
// - direction 1 transmits from current pointer
// - read without pointer write uses retained pointer
// - keep transmitting until master nack
// - pointer wraps from last to first
// - each start snapshots time into holding set
`include "rtcs_map.svh"
module rtcs_slave #(
	parameter logic [6:0] DEV_ADDR = `RTCS_DEV_ADDR // value is arbitrary
) (
	input wire logic link_clk_in,
	input wire logic reset_n_in,
	rtcs_if.dev bus,
	output rtcs_pkg::rtcs_ptr_t ptr_out,
	output logic [7:0] wr_data_out,
	output logic wr_strobe_out,
	input wire logic [7:0] rd_data_in,
	output logic snap_out,
	output logic busy_out
);
	import rtcs_pkg::*;
	rtcs_dev_st_t r_reg; // all state
	rtcs_dev_st_t r_next;
	logic scl_f; // filtered scl
	logic sda_f; // filtered sda
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	// ==========================================
	// line conditioning
	rtcs_filter u_scl_filt (
		.clk_in(link_clk_in),
		.reset_n_in(reset_n_in),
		.raw_in(bus.scl),
		.level_out(scl_f)
	);
	rtcs_filter u_sda_filt (
		.clk_in(link_clk_in),
		.reset_n_in(reset_n_in),
		.raw_in(bus.sda),
		.level_out(sda_f)
	);
	// ==========================================
	// pointer step with wrap from the last location to the first
	function automatic rtcs_ptr_t ptr_step(input rtcs_ptr_t p);
		if (p == `RTCS_PTR_LAST)
		begin
			return `RTCS_PTR_FIRST;
		end
		return rtcs_ptr_t'(p + 6'h01);
	endfunction
	// ==========================================
	// bus conditions; data moving while scl is high is a control event
	always_comb
	begin
		scl_rise = scl_f & ~r_reg.scl_q;
		scl_fall = ~scl_f & r_reg.scl_q;
		start_det = scl_f & r_reg.scl_q & r_reg.sda_q & ~sda_f;
		stop_det = scl_f & r_reg.scl_q & ~r_reg.sda_q & sda_f;
	end
	// ==========================================
	// protocol engine
	always_comb
	begin
		r_next = r_reg;
		r_next.scl_q = scl_f;
		r_next.sda_q = sda_f;
		r_next.wr_strobe = 1'b0;
		r_next.snap = 1'b0;
		if (start_det)
		begin
			// start or repeated start: always a fresh address phase
			r_next.state = DEV_HDR;
			r_next.bitcnt = 4'h0;
			r_next.drive_low = 1'b0;
			r_next.snap = 1'b1;
		end
		else if (stop_det)
		begin
			// stop frees the bus; pointer is kept for later reads
			r_next.state = DEV_IDLE;
			r_next.drive_low = 1'b0;
		end
		else
		begin
			unique case (r_reg.state)
				DEV_IDLE:
				begin
					// passive until a start
					r_next.drive_low = 1'b0;
				end
				DEV_HDR:
				begin
					// sample on the rising edge, msb first
					if (scl_rise)
					begin
						r_next.sh = {r_reg.sh[6:0], sda_f};
						r_next.bitcnt = r_reg.bitcnt + 4'h1;
					end
					else if (scl_fall && r_reg.bitcnt == `RTCS_ACK_BIT)
					begin
						if (r_reg.sh[7:1] == DEV_ADDR)
						begin
							// match: pull sda low over the ack pulse
							r_next.state = DEV_ADDR_ACK;
							r_next.rw = r_reg.sh[0];
							r_next.drive_low = 1'b1;
						end
						else
						begin
							// not ours: stay off the bus until next start
							r_next.state = DEV_IDLE;
						end
					end
				end
				DEV_ADDR_ACK:
				begin
					// ack ends at scl fall; change sda only while scl low
					if (scl_fall)
					begin
						r_next.bitcnt = 4'h0;
						if (r_reg.rw)
						begin
							// read: first byte from the current pointer
							r_next.state = DEV_TX;
							r_next.sh = rd_data_in;
							r_next.drive_low = ~rd_data_in[7];
						end
						else
						begin
							// write: first byte is the pointer
							r_next.state = DEV_RX;
							r_next.ptr_phase = 1'b1;
							r_next.drive_low = 1'b0;
						end
					end
				end
				DEV_RX:
				begin
					if (scl_rise)
					begin
						r_next.sh = {r_reg.sh[6:0], sda_f};
						r_next.bitcnt = r_reg.bitcnt + 4'h1;
					end
					else if (scl_fall && r_reg.bitcnt == `RTCS_ACK_BIT)
					begin
						// acknowledge every byte, no count limit
						r_next.state = DEV_RX_ACK;
						r_next.drive_low = 1'b1;
						r_next.ptr_phase = 1'b0;
						if (r_reg.ptr_phase)
						begin
							r_next.ptr = r_reg.sh[5:0];
						end
						else
						begin
							// store at pointer, then step it
							r_next.wr_data = r_reg.sh;
							r_next.wr_strobe = 1'b1;
						end
					end
				end
				DEV_RX_ACK:
				begin
					// the pointer steps after the strobe has used it
					if (r_reg.wr_strobe)
					begin
						r_next.ptr = ptr_step(r_reg.ptr);
					end
					if (scl_fall)
					begin
						r_next.state = DEV_RX;
						r_next.bitcnt = 4'h0;
						r_next.drive_low = 1'b0;
					end
				end
				DEV_TX:
				begin
					// next bit goes out just after scl falls
					if (scl_fall)
					begin
						if (r_reg.bitcnt == 4'h7)
						begin
							// release for the master's ack bit
							r_next.state = DEV_TX_ACK;
							r_next.drive_low = 1'b0;
							r_next.ptr = ptr_step(r_reg.ptr);
						end
						else
						begin
							r_next.sh = {r_reg.sh[6:0], 1'b0};
							r_next.drive_low = ~r_reg.sh[6];
							r_next.bitcnt = r_reg.bitcnt + 4'h1;
						end
					end
				end
				DEV_TX_ACK:
				begin
					if (scl_rise)
					begin
						r_next.acked = ~sda_f;
					end
					else if (scl_fall)
					begin
						r_next.bitcnt = 4'h0;
						if (r_reg.acked)
						begin
							// acknowledged: send the next location
							r_next.state = DEV_TX;
							r_next.sh = rd_data_in;
							r_next.drive_low = ~rd_data_in[7];
						end
						else
						begin
							// nack: leave sda high so the master can stop
							r_next.state = DEV_IDLE;
							r_next.drive_low = 1'b0;
						end
					end
				end
				default:
				begin
					r_next.state = DEV_IDLE;
					r_next.drive_low = 1'b0;
				end
			endcase
		end
		r_next.busy = (r_next.state != DEV_IDLE);
	end
	// ==========================================
	// registers on the link clock
	always_ff @(posedge link_clk_in)
	begin
		if (!reset_n_in)
		begin
			r_reg <= '{state: DEV_IDLE, scl_q: `RTCS_LINE_RESET,
				sda_q: `RTCS_LINE_RESET, bitcnt: 4'h0, sh: 8'h00, rw: 1'b0,
				ptr_phase: 1'b0, acked: 1'b0, ptr: `RTCS_PTR_FIRST,
				wr_data: 8'h00, wr_strobe: 1'b0, snap: 1'b0,
				drive_low: 1'b0, busy: 1'b0};
		end
		else
		begin
			r_reg <= r_next;
		end
	end
	// ==========================================
	// outputs; sda is open drain, enable high while pulling low
	assign bus.sda_s_o = 1'b0;
	assign bus.sda_s_oe = r_reg.drive_low;
	assign ptr_out = r_reg.ptr;
	assign wr_data_out = r_reg.wr_data;
	assign wr_strobe_out = r_reg.wr_strobe;
	assign snap_out = r_reg.snap;
	assign busy_out = r_reg.busy;
endmodule

//--- src/rtcs_master.sv
`include "rtcs_map.svh"
// ==========================================
// bus master: byte-level commands, scl divided from clk_in
module rtcs_master #(
	parameter int QUARTER = `RTCS_QUARTER // clk_in cycles per quarter scl period
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	rtcs_if.mst bus,
	input wire logic cmd_valid_in,
	input wire rtcs_pkg::rtcs_op_t cmd_op_in,
	input wire logic [7:0] cmd_data_in,
	input wire logic cmd_nack_in,
	output logic cmd_ready_out,
	output logic rsp_valid_out,
	output logic [7:0] rsp_data_out,
	output logic rsp_ack_out
);
	import rtcs_pkg::*;
	rtcs_host_st_t r_reg; // all state
	rtcs_host_st_t r_next;
	logic sda_f; // filtered line level
	logic tick; // end of a quarter
	logic take; // command accepted
	// ==========================================
	// sda comes back from the device's domain
	rtcs_filter u_sda_filt (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.raw_in(bus.sda),
		.level_out(sda_f)
	);
	// ==========================================
	// sequencer; four quarters per bit keep scl at or below 100 kHz
	always_comb
	begin
		r_next = r_reg;
		r_next.rsp_valid = 1'b0;
		tick = (r_reg.cnt == 8'(QUARTER - 1));
		take = cmd_valid_in & r_reg.ready;
		r_next.cnt = tick ? 8'h00 : 8'(r_reg.cnt + 8'h01);
		if (tick)
		begin
			r_next.phase = r_reg.phase + 2'h1;
		end
		unique case (r_reg.state)
			HST_IDLE, HST_HOLD:
			begin
				r_next.cnt = 8'h00;
				r_next.phase = 2'h0;
				if (take)
				begin
					r_next.bitcnt = 4'h0;
					r_next.sh = cmd_data_in;
					r_next.nack = cmd_nack_in;
					unique case (cmd_op_in)
						OP_START: r_next.state = HST_START;
						OP_WRITE: r_next.state = (r_reg.state == HST_HOLD) ? HST_BIT : HST_IDLE;
						OP_READ: r_next.state = (r_reg.state == HST_HOLD) ? HST_BIT : HST_IDLE;
						OP_STOP: r_next.state = (r_reg.state == HST_HOLD) ? HST_STOP : HST_IDLE;
					endcase
					r_next.rd = (cmd_op_in == OP_READ);
				end
			end
			HST_START:
			begin
				// release sda, raise scl, then sda falls with scl high
				if (tick)
				begin
					unique case (r_reg.phase)
						2'h0: r_next.sda_low = 1'b0;
						2'h1: r_next.scl_low = 1'b0;
						2'h2: r_next.sda_low = 1'b1;
						2'h3:
						begin
							r_next.scl_low = 1'b1;
							r_next.state = HST_HOLD;
						end
					endcase
				end
			end
			HST_BIT:
			begin
				if (tick)
				begin
					unique case (r_reg.phase)
						2'h0:
						begin
							// set sda a quarter into scl low
							if (r_reg.bitcnt != `RTCS_ACK_BIT)
							begin
								r_next.sda_low = ~r_reg.rd & ~r_reg.sh[7];
							end
							else
							begin
								// ack slot: ours on a read, nack ends it
								r_next.sda_low = r_reg.rd & ~r_reg.nack;
							end
						end
						2'h1: r_next.scl_low = 1'b0; // extra ack pulse too
						2'h2:
						begin
							// sample mid high period
							if (r_reg.bitcnt != `RTCS_ACK_BIT)
							begin
								r_next.sh = {r_reg.sh[6:0], sda_f};
							end
							else
							begin
								r_next.rsp_ack = ~sda_f;
							end
						end
						2'h3:
						begin
							r_next.scl_low = 1'b1;
							if (r_reg.bitcnt == `RTCS_ACK_BIT)
							begin
								r_next.state = HST_HOLD;
								r_next.rsp_valid = 1'b1;
								r_next.rsp_data = r_reg.sh;
							end
							else
							begin
								r_next.bitcnt = r_reg.bitcnt + 4'h1;
							end
						end
					endcase
				end
			end
			HST_STOP:
			begin
				// sda low, scl high, then sda rises with scl high
				if (tick)
				begin
					unique case (r_reg.phase)
						2'h0: r_next.sda_low = 1'b1;
						2'h1: r_next.scl_low = 1'b0;
						2'h2: r_next.sda_low = 1'b0;
						2'h3: r_next.state = HST_IDLE;
					endcase
				end
			end
			default:
			begin
				r_next.state = HST_IDLE;
				r_next.scl_low = 1'b0;
				r_next.sda_low = 1'b0;
			end
		endcase
		// a new start only once the bus is seen idle; scl is ours
		r_next.ready = ~take & ((r_next.state == HST_HOLD) | ((r_next.state == HST_IDLE) & sda_f));
	end
	// ==========================================
	// registers
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			r_reg <= '{state: HST_IDLE, cnt: 8'h00, phase: 2'h0, bitcnt: 4'h0,
				sh: 8'h00, rd: 1'b0, nack: 1'b0, scl_low: 1'b0, sda_low: 1'b0,
				ready: 1'b0, rsp_valid: 1'b0, rsp_data: 8'h00, rsp_ack: 1'b0};
		end
		else
		begin
			r_reg <= r_next;
		end
	end
	// ==========================================
	// outputs; both lines driven open drain
	assign bus.scl_m_o = 1'b0;
	assign bus.scl_m_oe = r_reg.scl_low;
	assign bus.sda_m_o = 1'b0;
	assign bus.sda_m_oe = r_reg.sda_low;
	assign cmd_ready_out = r_reg.ready;
	assign rsp_valid_out = r_reg.rsp_valid;
	assign rsp_data_out = r_reg.rsp_data;
	assign rsp_ack_out = r_reg.rsp_ack;
endmodule

//--- tb/rtcs_assertions.sv
`include "rtcs_map.svh"
// ==========================================
// wire-level checks on the shared two-wire bus
module rtcs_assertions #(
	parameter int QUARTER = `RTCS_QUARTER // clk_in cycles per quarter scl period
) (
	input wire logic clk_in,
	input wire logic link_clk_in,
	input wire logic reset_n_in,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_s_oe
);
	// ==========================================
	// helper state, sampled on the host clock
	typedef struct packed {
		logic [7:0] hi_cnt; // samples with scl high
		logic [7:0] lo_cnt; // samples with scl low
		logic scl_q;
		logic sda_q;
		logic [3:0] slot; // scl rises since start, wrapping from 9 back to 1 after each byte slot
		logic passive; // device must leave sda alone
	} rtcs_chk_st_t;
	rtcs_chk_st_t st_reg;
	rtcs_chk_st_t st_next;
	logic start_c; // sda falls, scl high
	logic stop_c; // sda rises, scl high
	logic rise_c; // scl rising
	assign start_c = st_reg.scl_q & scl & st_reg.sda_q & ~sda;
	assign stop_c = st_reg.scl_q & scl & ~st_reg.sda_q & sda;
	assign rise_c = ~st_reg.scl_q & scl;
	// next helper state; counters saturate so idle never wraps
	always_comb
	begin
		st_next = st_reg;
		st_next.scl_q = scl;
		st_next.sda_q = sda;
		st_next.hi_cnt = scl ? st_reg.hi_cnt + {7'h00, st_reg.hi_cnt != 8'hff} : 8'h00;
		st_next.lo_cnt = scl ? 8'h00 : st_reg.lo_cnt + {7'h00, st_reg.lo_cnt != 8'hff};
		if (start_c)
		begin
			st_next.slot = 4'h0;
			st_next.passive = 1'b0;
		end
		else if (rise_c)
		begin
			st_next.slot = (st_reg.slot == 4'h9) ? 4'h1 : st_reg.slot + 4'h1;
			// high ninth bit: nack, device off until next start
			if (st_reg.slot == 4'h8 && sda)
				st_next.passive = 1'b1;
		end
	end
	// idle bus counts as a long high phase, just past a byte boundary
	always_ff @(posedge clk_in)
	begin
		if (!reset_n_in)
			st_reg <= '{8'hff, 8'h00, 1'b1, 1'b1, 4'h1, 1'b1};
		else
			st_reg <= st_next;
	end
	// ==========================================
	// sequences and properties
	sequence s_start_hold;
		scl [*4];
	endsequence
	sequence s_bus_free;
		(scl && sda) [*8];
	endsequence
	property p_scl_high_min;
		@(posedge clk_in) disable iff (!reset_n_in)
		(st_reg.scl_q && !scl) |-> st_reg.hi_cnt >= 8'(2 * QUARTER - 1);
	endproperty
	property p_scl_low_min;
		@(posedge clk_in) disable iff (!reset_n_in)
		rise_c |-> st_reg.lo_cnt >= 8'(QUARTER);
	endproperty
	property p_dev_change_low;
		@(posedge link_clk_in) disable iff (!reset_n_in)
		$changed(sda_s_oe) |-> !scl;
	endproperty
	property p_start_hold;
		@(posedge clk_in) disable iff (!reset_n_in)
		start_c |-> s_start_hold;
	endproperty
	property p_stop_free;
		@(posedge clk_in) disable iff (!reset_n_in)
		stop_c |-> s_bus_free;
	endproperty
	property p_ack_low;
		@(posedge clk_in) disable iff (!reset_n_in)
		(sda_s_oe && rise_c) |-> (!sda && sda_s_oe) [*8];
	endproperty
	property p_passive;
		@(posedge clk_in) disable iff (!reset_n_in)
		st_reg.passive |-> !sda_s_oe;
	endproperty
	property p_frame;
		@(posedge clk_in) disable iff (!reset_n_in)
		// a condition rides the first pulse after a full nine-pulse slot
		(start_c || stop_c) |-> st_reg.slot == 4'h1;
	endproperty
	a_scl_high_min: assert property (p_scl_high_min)
		else $error("scl high phase too short");
	a_scl_low_min: assert property (p_scl_low_min)
		else $error("scl low phase too short");
	a_dev_change_low: assert property (p_dev_change_low)
		else $error("device moved sda while scl high");
	a_start_hold: assert property (p_start_hold)
		else $error("scl fell too soon after start");
	a_stop_free: assert property (p_stop_free)
		else $error("bus not idle after stop");
	a_ack_low: assert property (p_ack_low)
		else $error("sda not low through high phase");
	a_passive: assert property (p_passive)
		else $error("device drove sda after nack");
	a_frame: assert property (p_frame)
		else $error("start or stop inside a byte slot");
endmodule

//--- tb/tb_rtc_i2c_slave_port.sv
module tb_rtc_i2c_slave_port;
	timeunit 1ns;
	timeprecision 1ps;
	import rtcs_pkg::*;
	// ==========================================
	// signals; short quarter keeps the run brief
	localparam int QUARTER = 8;
	localparam logic [6:0] DEV = 7'h2a; // value is arbitrary
	logic clk_in;
	logic link_clk_in;
	logic reset_n_in;
	logic cmd_valid;
	rtcs_op_t cmd_op;
	logic [7:0] cmd_data;
	logic cmd_nack;
	logic cmd_ready;
	logic rsp_valid;
	logic [7:0] rsp_data;
	logic rsp_ack;
	rtcs_ptr_t ptr;
	logic [7:0] wr_data;
	logic wr_strobe;
	logic snap;
	logic busy;
	logic [7:0] mem [64]; // register file behind the device
	int n_errors;
	int checks_done;
	int n_snap; // start snapshots seen
	rtcs_if i_rtcs_if();
	rtcs_master #(.QUARTER(QUARTER)) i_rtcs_master (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.bus(i_rtcs_if), .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_data_in(cmd_data),
		.cmd_nack_in(cmd_nack), .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid),
		.rsp_data_out(rsp_data), .rsp_ack_out(rsp_ack));
	rtcs_slave #(.DEV_ADDR(DEV)) i_rtcs_slave (.link_clk_in(link_clk_in),
		.reset_n_in(reset_n_in), .bus(i_rtcs_if), .ptr_out(ptr), .wr_data_out(wr_data),
		.wr_strobe_out(wr_strobe), .rd_data_in(mem[ptr]), .snap_out(snap), .busy_out(busy));
	rtcs_assertions #(.QUARTER(QUARTER)) i_rtcs_assertions (.clk_in(clk_in),
		.link_clk_in(link_clk_in), .reset_n_in(reset_n_in), .scl(i_rtcs_if.scl),
		.sda(i_rtcs_if.sda), .sda_s_oe(i_rtcs_if.sda_s_oe));
	// ==========================================
	// clocks: link clock free-running, phase offset on purpose
	initial
	begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	initial
	begin
		link_clk_in = 1'b0;
		#3;
		forever #6 link_clk_in = ~link_clk_in;
	end
	// register file store and snapshot counter; off edge, so pulses are settled
	always @(negedge link_clk_in)
	begin
		if (wr_strobe === 1'b1)
			mem[ptr] <= wr_data;
		if (snap === 1'b1)
			n_snap++;
	end
	// ==========================================
	// compare, verdict and command tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		if (n_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// bounded wait on falling edges; a hang ends the run
	task automatic wait_hi(ref logic flag, input int lim);
		int i;
		i = 0;
		while (flag !== 1'b1 && i < lim)
		begin
			@(negedge clk_in);
			i++;
		end
		if (flag !== 1'b1)
		begin
			n_errors++;
			summarize();
		end
	endtask
	// one command, held until the edge where ready is seen
	task automatic cmd(input rtcs_op_t op, input logic [7:0] d, input logic nk);
		wait_hi(cmd_ready, 2000);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_data = d;
		cmd_nack = nk;
		@(negedge clk_in);
		cmd_valid = 1'b0;
		// bytes answer with a pulse; conditions are done once ready returns
		if (op == OP_WRITE || op == OP_READ)
			wait_hi(rsp_valid, 400);
		else
			wait_hi(cmd_ready, 400);
	endtask
	task automatic wr(input logic [7:0] d, input logic ack);
		cmd(OP_WRITE, d, 1'b0);
		chk(rsp_data, d);
		chk({7'h00, rsp_ack}, {7'h00, ack});
	endtask
	task automatic rd(input logic nk, input logic [7:0] exp);
		cmd(OP_READ, 8'h00, nk);
		chk(rsp_data, exp);
		chk({7'h00, rsp_ack}, {7'h00, ~nk});
	endtask
	// ==========================================
	// main sequence
	initial
	begin
		reset_n_in = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = OP_START;
		cmd_data = 8'h00;
		cmd_nack = 1'b0;
		n_errors = 0;
		checks_done = 0;
		n_snap = 0;
		for (int i = 0; i < 64; i++)
			mem[i] = 8'(i) ^ 8'h5c;
		// two host clocks of reset; filters restart at the idle level
		repeat (2) @(negedge clk_in);
		reset_n_in = 1'b1;
		// write running across the top of the pointer space
		cmd(OP_START, 8'h00, 1'b0);
		wr({DEV, 1'b0}, 1'b1);
		wr(8'h3e, 1'b1);
		wr(8'ha5, 1'b1);
		wr(8'h5a, 1'b1);
		wr(8'hc3, 1'b1);
		cmd(OP_STOP, 8'h00, 1'b0);
		chk(mem[62], 8'ha5);
		chk(mem[63], 8'h5a);
		chk(mem[0], 8'hc3);
		chk({2'b00, ptr}, 8'h01);
		chk({7'h00, busy}, 8'h00);
		// read from the retained pointer, no pointer byte
		cmd(OP_START, 8'h00, 1'b0);
		wr({DEV, 1'b1}, 1'b1);
		rd(1'b0, mem[1]);
		rd(1'b0, mem[2]);
		rd(1'b1, mem[3]);
		cmd(OP_STOP, 8'h00, 1'b0);
		// repeated start turns a pointer write into a read
		cmd(OP_START, 8'h00, 1'b0);
		wr({DEV, 1'b0}, 1'b1);
		wr(8'h3f, 1'b1);
		cmd(OP_START, 8'h00, 1'b0);
		wr({DEV, 1'b1}, 1'b1);
		rd(1'b0, 8'h5a);
		rd(1'b1, 8'hc3);
		cmd(OP_STOP, 8'h00, 1'b0);
		// foreign address: no acknowledge, nothing stored
		cmd(OP_START, 8'h00, 1'b0);
		wr({DEV ^ 7'h01, 1'b0}, 1'b0);
		wr(8'h10, 1'b0);
		cmd(OP_STOP, 8'h00, 1'b0);
		chk({2'b00, ptr}, 8'h01);
		chk(mem[1], 8'h5d);
		chk(8'(n_snap), 8'h05);
		summarize();
	end
endmodule
